// ### flash_protect_dev.sv
// Purpose: decides when the flash array may program or erase
// Assumes: CPU writes registers through the register port
// Notes: all state is one struct, registered in one process
`timescale 1ns/1ps
module flash_protect_dev (
  input  wire logic                           clk,
  input  wire logic                           reset,
  flash_protect_if.device                     bus,
  input  wire logic                           vpp_present,
  input  wire logic                           wdt_reset,
  input  wire logic                           standby_entry,
  input  wire logic                           hw_standby,
  input  wire logic                           irq_in,
  input  wire flash_protect_pkg::addr_type    access_addr,
  output logic                                array_program_en,
  output logic                                array_erase_en,
  output logic                                program_verify_en,
  output logic                                erase_verify_en,
  output logic                                prewrite_verify_en,
  output logic [15:0]                         block_enable,
  output logic                                array_read_valid,
  output logic                                overlap_hit,
  output flash_protect_pkg::addr_type         overlap_ram_addr,
  output logic                                irq_protect_active
);
  import flash_protect_pkg::*;

  // Whole state of the block
  typedef struct packed {
    byte_type flash_control_reg;      // Program/erase/verify requests
    byte_type erase_block_select_lo;  // Blocks 0..7
    byte_type erase_block_select_hi;  // Blocks 8..15
    byte_type wait_state_control_reg; // Overlap bits and wait settings
    logic     int_protect;            // Sticky interrupt abort state
    byte_type rdata;                  // Registered read answer
    logic     rvalid;                 // Read answer marker
  } state_type;

  state_type state;       // Registered state
  state_type next_state;  // Next value

  // Decode of the overlap bits
  function automatic overlap_type decode_overlap(input byte_type ws);
    unique case ({ws[`WS_OVERLAP_HI_BIT], ws[`WS_OVERLAP_LO_BIT]})
      2'b00: decode_overlap = OVL_NONE;
      2'b01: decode_overlap = OVL_LO_ONLY;
      2'b10: decode_overlap = OVL_HI_ONLY;
      2'b11: decode_overlap = OVL_BOTH;
    endcase
  endfunction

  // Address test against an inclusive window
  function automatic logic in_window(input addr_type a, input addr_type lo,
                                     input addr_type hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction

  overlap_type ovl;          // Current overlap selection
  logic        emul_protect; // One overlap bit alone
  logic        block_none;   // No block selected
  logic        soft_protect; // Any software protection
  logic        hw_protect;   // Any hardware protection
  logic        reinit;       // Hardware event clearing registers
  logic        pe_request;   // Program or erase requested
  logic [15:0] blocks;       // Raw block selects

  // Protection conditions
  always_comb begin
    ovl          = decode_overlap(state.wait_state_control_reg);
    blocks       = {state.erase_block_select_hi,
                    state.erase_block_select_lo};
    emul_protect = (ovl == OVL_LO_ONLY) || (ovl == OVL_HI_ONLY);
    block_none   = (blocks == 16'h0000);
    soft_protect = block_none || emul_protect;
    pe_request   = state.flash_control_reg[`FC_PROGRAM_BIT] ||
                   state.flash_control_reg[`FC_ERASE_BIT];
    reinit       = !vpp_present || wdt_reset || standby_entry;
    hw_protect   = reinit || state.int_protect;
  end

  // Next-state logic: register writes, reinit, interrupt latch
  always_comb begin
    next_state        = state;
    next_state.rvalid = bus.rd_en;
    // Register writes from the CPU
    if (bus.wr_en) begin
      unique case (bus.sel)
        `SEL_FLASH_CTRL: begin
          // Status bit is read-only
          next_state.flash_control_reg = {1'b0, bus.wdata[6:0]};
        end
        `SEL_ERASE_LO:   next_state.erase_block_select_lo = bus.wdata;
        `SEL_ERASE_HI:   next_state.erase_block_select_hi = bus.wdata;
        `SEL_WAIT_STATE: next_state.wait_state_control_reg = bus.wdata;
      endcase
    end
    // Read answer, one cycle after the strobe
    if (bus.rd_en) begin
      unique case (bus.sel)
        `SEL_FLASH_CTRL: begin
          next_state.rdata = state.flash_control_reg;
          next_state.rdata[`FC_VPP_OK_BIT] = vpp_present;
        end
        `SEL_ERASE_LO:   next_state.rdata = state.erase_block_select_lo;
        `SEL_ERASE_HI:   next_state.rdata = state.erase_block_select_hi;
        `SEL_WAIT_STATE: next_state.rdata = state.wait_state_control_reg;
      endcase
    end
    if (irq_in && pe_request) begin
      next_state.int_protect = 1'b1;
    end
    if (reinit) begin
      next_state.flash_control_reg     = `FLASH_CTRL_RESET;
      next_state.erase_block_select_lo = `ERASE_SEL_RESET;
      next_state.erase_block_select_hi = `ERASE_SEL_RESET;
    end
    // only a reset clears interrupt protect
    if (wdt_reset) begin
      next_state.int_protect = 1'b0;
    end
    // Software standby keeps overlap bits; hardware standby does not
    if (wdt_reset || hw_standby) begin
      next_state.wait_state_control_reg = `WAIT_STATE_RESET;
    end
  end

  // State register; reset takes constants only
  // reset initialises every register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state.flash_control_reg      <= `FLASH_CTRL_RESET;
      state.erase_block_select_lo  <= `ERASE_SEL_RESET;
      state.erase_block_select_hi  <= `ERASE_SEL_RESET;
      state.wait_state_control_reg <= `WAIT_STATE_RESET;
      state.int_protect            <= 1'b0;
      state.rdata                  <= 8'h00;
      state.rvalid                 <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign bus.rdata  = state.rdata;
  assign bus.rvalid = state.rvalid;

  // Array enables, evaluated every cycle from the registered state.
  // The interrupt is also looked at directly so that the abort does
  // not wait for the latch: the cell is cut off in the same cycle.
  always_comb begin
    // abort in the cycle the interrupt comes
    array_program_en = state.flash_control_reg[`FC_PROGRAM_BIT] &&
                       !soft_protect && !hw_protect && !irq_in;
    array_erase_en   = state.flash_control_reg[`FC_ERASE_BIT] &&
                       !soft_protect && !hw_protect && !irq_in;
    // emulation or hardware blanks every block at once
    block_enable     = (emul_protect || hw_protect) ? 16'h0000 : blocks;
  end

  // Verify modes: only voltage loss, watchdog reset and standby entry stop them
  always_comb begin
    // verify kept under soft and interrupt protection
    program_verify_en  = vpp_present && !wdt_reset && !standby_entry &&
                         state.flash_control_reg[`FC_PROG_VERIFY_BIT];
    erase_verify_en    = vpp_present && !wdt_reset && !standby_entry &&
                         state.flash_control_reg[`FC_ERASE_VERIFY_BIT];
    // Prewrite verify: all four control bits clear
    prewrite_verify_en = vpp_present && !wdt_reset && !standby_entry &&
                         (state.flash_control_reg[3:0] == 4'h0);
  end

  // array data not trusted while a request is set
  assign array_read_valid   = !pe_request;
  assign irq_protect_active = state.int_protect;

  // RAM overlap decode; RAM writes there bypass emulation protection
  always_comb begin
    overlap_hit      = 1'b0;
    overlap_ram_addr = access_addr;
    unique case (ovl)
      OVL_NONE: begin
        overlap_hit = 1'b0;
      end
      OVL_LO_ONLY: begin
        overlap_hit = in_window(access_addr, `OVL_LO_BASE, `OVL_LO_LIMIT);
      end
      OVL_HI_ONLY: begin
        overlap_hit = in_window(access_addr, `OVL_LO_BASE, `OVL_HI_LIMIT);
      end
      OVL_BOTH: begin
        // small block mapped only with voltage present
        overlap_hit = vpp_present &&
          in_window(access_addr, `OVL_SMALL_BASE, `OVL_SMALL_LIMIT);
      end
    endcase
    if (overlap_hit) begin
      // Low seven address bits carry over; windows are aligned
      overlap_ram_addr = (ovl == OVL_BOTH) ?
        (`OVL_SMALL_RAM | {9'h000, access_addr[6:0]}) :
        addr_type'(`OVL_LO_RAM + (access_addr - `OVL_LO_BASE));
    end
  end
endmodule

// ### flash_protect_map.svh
// Purpose: offsets, field positions, reset values for flash protection
// Assumes: included by package and modules
// Notes: register selects are indices on the internal register port
`ifndef FLASH_PROTECT_MAP_SVH
`define FLASH_PROTECT_MAP_SVH

// Register selects on the internal register port
`define SEL_FLASH_CTRL     2'h0
`define SEL_ERASE_LO       2'h1
`define SEL_ERASE_HI       2'h2
`define SEL_WAIT_STATE     2'h3

// Flash control field positions
`define FC_PROGRAM_BIT     0
`define FC_ERASE_BIT       1
`define FC_PROG_VERIFY_BIT 2
`define FC_ERASE_VERIFY_BIT 3
`define FC_VPP_OK_BIT      7

// Wait-state control field positions
`define WS_OVERLAP_HI_BIT  7
`define WS_OVERLAP_LO_BIT  6

// Reset values
`define FLASH_CTRL_RESET   8'h00
`define ERASE_SEL_RESET    8'h00
`define WAIT_STATE_RESET   8'h08

// Overlap windows: flash side base/limit and RAM side base
`define OVL_SMALL_BASE     16'h0000
`define OVL_SMALL_LIMIT    16'h007f
`define OVL_SMALL_RAM      16'hf800
`define OVL_LO_BASE        16'h0080
`define OVL_LO_LIMIT       16'h00ff
`define OVL_LO_RAM         16'hf880
`define OVL_HI_LIMIT       16'h017f

// Boot handler region in RAM
`define BOOT_HANDLER_BASE  16'hf780
`define BOOT_HANDLER_LIMIT 16'hf78f

`endif

// ### flash_protect_pkg.sv
// Purpose: shared types for the flash protection block
// Assumes: map header holds all numbers
// Notes: none
package flash_protect_pkg;
  `include "flash_protect_map.svh"

  typedef logic [1:0]  reg_sel_type;
  typedef logic [7:0]  byte_type;
  typedef logic [15:0] addr_type;

  // Overlap selection decoded from the two overlap bits
  typedef enum logic [1:0] {
    OVL_NONE,
    OVL_LO_ONLY,
    OVL_HI_ONLY,
    OVL_BOTH
  } overlap_type;
endpackage

// ### flash_protect_if.sv
// Purpose: internal register port between CPU end and flash protection
// Assumes: single clock, reads answered one cycle later
// Notes: no clocking block
`timescale 1ns/1ps
interface flash_protect_if;
  import flash_protect_pkg::*;
  logic        wr_en;   // Write strobe, one cycle
  logic        rd_en;   // Read strobe, one cycle
  reg_sel_type sel;     // Register select
  byte_type    wdata;   // Write data
  byte_type    rdata;   // Read data, valid cycle after rd_en
  logic        rvalid;  // Read answer marker

  modport device (input wr_en, rd_en, sel, wdata, output rdata, rvalid);
  modport cpu    (output wr_en, rd_en, sel, wdata, input rdata, rvalid);
endinterface

// ### flash_protect_cpu.sv
// Purpose: CPU end driving the flash protection register port
// Assumes: one request at a time, reads answered one cycle later
// Notes: guards overlap setup order and boot-area writes
`timescale 1ns/1ps
module flash_protect_cpu (
  input  wire logic                           clk,
  input  wire logic                           reset,
  flash_protect_if.cpu                        bus,
  input  wire logic                           req_valid,
  input  wire logic                           req_write,
  input  wire flash_protect_pkg::reg_sel_type req_sel,
  input  wire flash_protect_pkg::byte_type    req_wdata,
  input  wire logic                           vector_stored,
  input  wire logic                           boot_mode,
  input  wire logic                           boot_no_irq,
  input  wire flash_protect_pkg::addr_type    ram_write_addr,
  input  wire logic                           ram_write_en,
  output logic                                req_ready,
  output logic                                req_refused,
  output logic                                rsp_valid,
  output flash_protect_pkg::byte_type         rsp_rdata,
  output logic                                ram_write_ok
);
  import flash_protect_pkg::*;

  // All state of this end
  typedef struct packed {
    logic     boot_clear_done; // Overlap clear issued after boot
    logic     refused;         // Last request was refused
    logic     rsp_valid;       // Registered answer marker
    byte_type rsp_rdata;       // Registered answer data
  } cpu_state_type;

  cpu_state_type state;       // Registered state
  cpu_state_type next_state;  // Next value
  logic          both_set;    // Request sets both overlap bits
  logic          boot_clear;  // Clearing overlap this cycle

  // Request filter and bus drive
  always_comb begin
    next_state           = state;
    next_state.rsp_valid = bus.rvalid;
    next_state.refused   = 1'b0;
    if (bus.rvalid) begin
      next_state.rsp_rdata = bus.rdata;
    end
    both_set = req_write && (req_sel == `SEL_WAIT_STATE) &&
               req_wdata[`WS_OVERLAP_HI_BIT] &&
               req_wdata[`WS_OVERLAP_LO_BIT];
    // boot user without interrupts clears overlap first
    boot_clear = boot_mode && boot_no_irq && !state.boot_clear_done;
    bus.wr_en = 1'b0;
    bus.rd_en = 1'b0;
    bus.sel   = req_sel;
    bus.wdata = req_wdata;
    req_ready = !boot_clear;
    if (boot_clear) begin
      bus.wr_en = 1'b1;
      bus.sel   = `SEL_WAIT_STATE;
      bus.wdata = `WAIT_STATE_RESET;
      next_state.boot_clear_done = 1'b1;
    end else if (req_valid) begin
      // both overlap bits only after vector stored
      if (both_set && !vector_stored) begin
        next_state.refused = 1'b1;
      end else begin
        bus.wr_en = req_write;
        bus.rd_en = !req_write;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign req_refused = state.refused;
  assign rsp_valid   = state.rsp_valid;
  assign rsp_rdata   = state.rsp_rdata;

  // boot handler RAM is off limits in boot mode
  assign ram_write_ok = ram_write_en && !(boot_mode &&
    (ram_write_addr >= `BOOT_HANDLER_BASE) &&
    (ram_write_addr <= `BOOT_HANDLER_LIMIT));
endmodule

// ### flash_protect_props.sv
// Purpose: concurrent checks on the flash protection enables
// Assumes: one clock, reset asynchronous and active high
// Notes: sees register port strobes, voltage, reinit and interrupt inputs, and array gating outputs
`timescale 1ns/1ps
module flash_protect_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic        rvalid,
  input wire logic        vpp_present,
  input wire logic        wdt_reset,
  input wire logic        standby_entry,
  input wire logic        irq_in,
  input wire logic        array_program_en,
  input wire logic        array_erase_en,
  input wire logic        program_verify_en,
  input wire logic        erase_verify_en,
  input wire logic [15:0] block_enable,
  input wire logic        array_read_valid,
  input wire logic        irq_protect_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Program or erase live with no write pending that could clear it
  sequence busy_live;
    (array_program_en || array_erase_en) && !wr_en;
  endsequence
  // Interrupt with no reinit source competing
  sequence irq_hit;
    irq_in && vpp_present && !wdt_reset && !standby_entry;
  endsequence
  chk_read_answer: assert property (rd_en |=> rvalid)
    else $error("read strobe not answered next cycle");
  chk_rvalid_cause: assert property (rvalid |-> $past(rd_en))
    else $error("read answer without a read strobe");
  chk_no_block: assert property (
    block_enable == 16'h0000 |-> !array_program_en && !array_erase_en)
    else $error("array enabled with no block selected");
  chk_vpp_blocks: assert property (!vpp_present |->
    !array_program_en && !array_erase_en &&
    !program_verify_en && !erase_verify_en)
    else $error("enable seen without programming voltage");
  chk_reinit_clear: assert property (
    !vpp_present || wdt_reset || standby_entry |=> block_enable == 16'h0000)
    else $error("block selects survived reinit");
  chk_irq_abort: assert property (irq_in |->
    !array_program_en && !array_erase_en)
    else $error("program or erase live during interrupt");
  chk_irq_latch: assert property (
    busy_live ##1 irq_hit |=> irq_protect_active)
    else $error("interrupt protect not entered");
  chk_irq_sticky: assert property (
    irq_protect_active && !wdt_reset |=> irq_protect_active)
    else $error("interrupt protect dropped without reset");
  chk_irq_blocks: assert property (irq_protect_active |->
    !array_program_en && !array_erase_en)
    else $error("program or erase under interrupt protect");
  chk_read_invalid: assert property (
    array_program_en || array_erase_en |-> !array_read_valid)
    else $error("array read valid while busy");
endmodule

// ### flash_write_erase_protection_test.sv
// Purpose: directed test of both ends of the flash protection port
// Assumes: CPU end drives the device over the shared interface
// Notes: boot inputs raised only in the last test
`timescale 1ns/1ps
module flash_write_erase_protection_test;
  import flash_protect_pkg::*;
  logic        clk, reset, vpp_present, wdt_reset, standby_entry;
  logic        hw_standby, irq_in, req_valid, req_write, vector_stored;
  logic        boot_mode, boot_no_irq, ram_write_en, req_ready;
  logic        req_refused, rsp_valid, ram_write_ok, refused_seen;
  logic        array_program_en, array_erase_en, program_verify_en;
  logic        erase_verify_en, prewrite_verify_en, array_read_valid;
  logic        overlap_hit, irq_protect_active;
  reg_sel_type req_sel;
  byte_type    req_wdata, rsp_rdata;
  addr_type    access_addr, ram_write_addr, overlap_ram_addr;
  logic [15:0] block_enable;
  int          error_cnt, cmp_count;
  byte_type    rv [4] = '{8'h80, 8'h00, 8'h00, 8'h08}; // Reset values
  flash_protect_if bus_if ();
  flash_protect_dev u_flash_protect_dev (.clk, .reset, .bus(bus_if),
    .vpp_present, .wdt_reset, .standby_entry, .hw_standby, .irq_in,
    .access_addr, .array_program_en, .array_erase_en, .program_verify_en,
    .erase_verify_en, .prewrite_verify_en, .block_enable, .array_read_valid,
    .overlap_hit, .overlap_ram_addr, .irq_protect_active);
  flash_protect_cpu u_flash_protect_cpu (.clk, .reset, .bus(bus_if),
    .req_valid, .req_write, .req_sel, .req_wdata, .vector_stored,
    .boot_mode, .boot_no_irq, .ram_write_addr, .ram_write_en, .req_ready,
    .req_refused, .rsp_valid, .rsp_rdata, .ram_write_ok);
  flash_protect_props u_props (.clk, .reset, .wr_en(bus_if.wr_en),
    .rd_en(bus_if.rd_en), .rvalid(bus_if.rvalid), .vpp_present, .wdt_reset,
    .standby_entry, .irq_in, .array_program_en, .array_erase_en,
    .program_verify_en, .erase_verify_en, .block_enable, .array_read_valid,
    .irq_protect_active);
  // 100 MHz clock
  always #5 clk = ~clk;
  // Compare and count, unknowns never match
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Hold a request from a falling edge until the CPU end takes it
  task automatic issue(input logic wr, input int s, input byte_type d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_sel = reg_sel_type'(s);
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  // Write, then let it reach the register; note any refusal
  task automatic wr(input int s, input byte_type d);
    issue(1'b1, s, d);
    refused_seen = req_refused;
    repeat (3) begin
      @(negedge clk);
      refused_seen |= req_refused;
    end
  endtask
  // Read with a bounded wait on the answer pulse
  task automatic rd(input int s, input byte_type exp);
    int n;
    n = 0;
    issue(1'b0, s, 8'h00);
    while (rsp_valid !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("register read", {8'h00, exp}, {8'h00, rsp_rdata});
  endtask
  // One pulse of a reinit or standby input, one cycle wide
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge clk);
    sig = 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog: tests need just over a hundred cycles
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {clk, wdt_reset, standby_entry, hw_standby, irq_in, req_valid} = '0;
    {req_write, vector_stored, boot_mode, boot_no_irq, ram_write_en} = '0;
    {req_sel, req_wdata, access_addr, ram_write_addr} = '0;
    {error_cnt, cmp_count, refused_seen} = '0;
    vpp_present = 1'b1;
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    for (int i = 0; i < 4; i++) rd(i, rv[i]);
    $display("reset values done");
    wr(0, 8'h01);
    chk("program no block", 0, array_program_en);
    wr(1, 8'h01);
    chk("program one block", 1, array_program_en);
    chk("read while busy", 0, array_read_valid);
    wr(2, 8'h80);
    chk("block pair", 16'h8001, block_enable);
    wr(0, 8'h02);
    chk("erase allowed", 1, array_erase_en);
    $display("block protect done");
    wr(3, 8'h48);
    chk("erase lo overlap", 0, array_erase_en);
    ram_write_addr = 16'hf880;
    ram_write_en = 1'b1;
    #1 chk("overlap ram write", 1, ram_write_ok);
    ram_write_en = 1'b0;
    access_addr = 16'h0080;
    #1 chk("lo overlap hit", 1, overlap_hit);
    chk("lo overlap ram addr", 16'hf880, overlap_ram_addr);
    wr(3, 8'h88);
    chk("erase hi overlap", 0, array_erase_en);
    chk("hi overlap blocks", 0, block_enable);
    wr(3, 8'hc8);
    chk("early overlap refused", 1, refused_seen);
    vector_stored = 1'b1;
    wr(3, 8'hc8);
    chk("both overlap erase", 1, array_erase_en);
    access_addr = 16'h0006;
    #1 chk("vector hit", 1, overlap_hit);
    chk("vector ram addr", 16'hf806, overlap_ram_addr);
    rd(3, 8'hc8);
    wr(3, 8'h08);
    $display("emulation protect done");
    irq_in = 1'b1;
    #1 chk("erase on irq", 0, array_erase_en);
    @(negedge clk);
    irq_in = 1'b0;
    #1 chk("irq protect", 1, irq_protect_active);
    chk("erase after irq", 0, array_erase_en);
    rd(0, 8'h82);
    rd(1, 8'h01);
    wr(0, 8'h04);
    chk("verify under irq", 1, program_verify_en);
    pulse(wdt_reset);
    chk("irq cleared", 0, irq_protect_active);
    chk("wdt clears blocks", 0, block_enable);
    rd(0, 8'h80);
    $display("interrupt protect done");
    wr(0, 8'h08);
    chk("erase verify", 1, erase_verify_en);
    wr(0, 8'h00);
    chk("prewrite verify", 1, prewrite_verify_en);
    wr(1, 8'h01);
    wr(0, 8'h05);
    chk("program again", 1, array_program_en);
    chk("verify with program", 1, program_verify_en);
    vpp_present = 1'b0;
    #1 chk("no voltage program", 0, array_program_en);
    chk("no voltage verify", 0, program_verify_en);
    @(negedge clk);
    vpp_present = 1'b1;
    chk("no voltage blocks", 0, block_enable);
    rd(0, 8'h80);
    $display("voltage protect done");
    wr(3, 8'h48);
    wr(1, 8'h01);
    pulse(standby_entry);
    chk("standby blocks", 0, block_enable);
    rd(1, 8'h00);
    rd(3, 8'h48);
    pulse(hw_standby);
    rd(3, 8'h08);
    $display("standby protect done");
    wr(3, 8'hc8);
    boot_mode = 1'b1;
    ram_write_addr = 16'hf785;
    ram_write_en = 1'b1;
    #1 chk("boot area write", 0, ram_write_ok);
    ram_write_en = 1'b0;
    boot_no_irq = 1'b1;
    @(negedge clk);
    rd(3, 8'h08);
    {boot_mode, boot_no_irq} = '0;
    $display("boot mode done");
    tally_and_finish();
  end
endmodule
